// ==== core/oss_pkg.sv ====
/*
  Constants, field layout and decode helpers for the oscillator source
  select block. Assumes a 100 MHz system clock and an APB register bus.
*/
package oss_pkg;

  // Clock and timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int SUB_TIMEOUT_NS = 100000;
  localparam int SUB_TIMEOUT_CYC = SUB_TIMEOUT_NS / CLK_PERIOD_NS;

  // Register byte offsets
  localparam logic [11:0] OFS_CTRL = 12'h000;
  localparam logic [11:0] OFS_STAT = 12'h004;
  localparam logic [11:0] OFS_ERR  = 12'h008;
  localparam logic [11:0] OFS_OPT  = 12'h00c;

  // Option byte addresses and fields
  localparam logic [19:0] OPT_LS_ADDR = 20'h000c0;
  localparam logic [19:0] OPT_HS_ADDR = 20'h000c2;
  localparam int LS_RUN_BIT = 4;
  localparam int HS_SEL_LSB = 0;
  localparam int HS_SEL_W   = 5;

  // Control register fields
  localparam int CTRL_CPU_LSB   = 0;
  localparam int CTRL_PER_BIT   = 2;
  localparam int CTRL_EXT_BIT   = 3;
  localparam int CTRL_MODE_LSB  = 4;
  localparam int CTRL_LSRUN_BIT = 6;
  localparam int CTRL_SUBRUN_BIT = 7;
  localparam int CTRL_LSC_LSB   = 8;

  // Status register fields
  localparam int STAT_OSC_LSB  = 0;
  localparam int STAT_INT_LSB  = 8;
  localparam int STAT_DIV_BIT  = 14;
  localparam int STAT_VAL_BIT  = 15;
  localparam int STAT_LS_BIT   = 16;
  localparam int STAT_CPU_LSB  = 17;
  localparam int STAT_PER_BIT  = 19;
  localparam int STAT_ALIVE_BIT = 20;
  localparam int STAT_CODE_LSB = 24;

  // Error register bits, write one to clear
  localparam int ERR_CODE_BIT  = 0;
  localparam int ERR_LSCPU_BIT = 1;
  localparam int ERR_SUB_BIT   = 2;

  // Reset values and the undivided frequency limit
  localparam logic [1:0] RST_MODE = 2'h0;
  localparam logic [3:0] RST_LSC  = 4'h0;
  localparam logic [4:0] HS_SAFE_CODE = 5'h08;
  localparam logic [6:0] HS_UNDIV_MAX_MHZ = 7'h20;

  // Clock source encodings
  typedef enum logic [1:0] {SRC_HS = 2'h0, SRC_SUB = 2'h1, SRC_LS = 2'h2} oss_src_t;

  // Start-up sequence
  typedef enum logic {BOOT_CAPTURE, BOOT_RUN} oss_boot_t;

  // Frequency select code to on-chip oscillator frequency in MHz, 0 if unassigned
  function automatic logic [6:0] hs_mhz(input logic [4:0] code);
    unique case (code)
      5'h00:   hs_mhz = 7'h40;
      5'h01:   hs_mhz = 7'h30;
      5'h02:   hs_mhz = 7'h20;
      5'h03:   hs_mhz = 7'h18;
      5'h04:   hs_mhz = 7'h10;
      5'h05:   hs_mhz = 7'h0c;
      5'h06:   hs_mhz = 7'h08;
      5'h07:   hs_mhz = 7'h04;
      5'h08:   hs_mhz = 7'h01;
      default: hs_mhz = 7'h00;
    endcase
  endfunction

endpackage

// ==== core/oss_select_top.sv ====
/*
  Oscillator source select: picks the CPU and peripheral clock sources,
  decodes the on-chip oscillator frequency from the option byte, routes
  the low-speed oscillator to its consumers and steers the subsystem
  oscillator. Registers sit on APB. Assumes the option bytes are loaded
  and steady on OPT_* when RST falls, and come from the CLK domain.

  // How it works
  // R1 - On-chip oscillator runs at one of nine frequencies
  // R2 - 64 or 48 MHz halved for internal clock
  // R3 - 32 MHz and below pass undivided
  // R4 - Reset leaves CPU on on-chip oscillator
  // R5 - Low-speed clock routed to four timer consumers
  // R6 - Low-speed clock never accepted as CPU source
  // R7 - Option bit 4 starts or stops low-speed oscillator
  // R8 - Subsystem clock may feed CPU and peripherals
  // R9 - Subsystem input from crystal or external clock
  // R10 - Subsystem oscillation mode trades power against margin
  // R11 - Frequency code comes from option byte field
  // R12 - Unassigned frequency codes are flagged invalid
*/
`timescale 1ns/1ps
module oss_select_top
  import oss_pkg::*;
#(
  parameter int SUB_TIMEOUT = SUB_TIMEOUT_CYC
)
(
  // Clock, reset, enable
  input  wire logic        CLK,
  input  wire logic        RST,
  input  wire logic        CE,
  // APB slave
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [11:0] PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  // Option bytes from the nonvolatile loader
  input  wire logic [7:0]  OPT_LS_BYTE,
  input  wire logic [7:0]  OPT_HS_BYTE,
  // Subsystem clock pins
  input  wire logic        SUB_EXT_CLOCK_IN,
  input  wire logic        SUB_CRYSTAL_IN,
  output logic             SUB_OSC_EN,
  output logic             SUB_EXT_SEL,
  output logic [1:0]       SUB_OSC_MODE,
  // High-speed on-chip oscillator
  output logic [6:0]       HS_OSC_FREQ,
  output logic [5:0]       HS_INTERNAL_CLOCK,
  output logic             HS_DIV2,
  output logic             HS_FREQ_VALID,
  // Source selection
  output logic [1:0]       CPU_CLK_SRC,
  output logic             PERIPH_CLK_SRC,
  output logic             LS_OSC_RUN,
  output logic [3:0]       LS_CONSUMER_SEL,
  output logic             SUB_CLK_OK
);

  oss_sub_if sub_lnk ();

  // Bus state
  logic [31:0] prdata_q;
  logic [31:0] prdata_d;
  logic        pready_q;
  logic        pready_d;
  logic        pslverr_q;
  logic        pslverr_d;

  // Control state
  oss_boot_t   boot_q;
  oss_boot_t   boot_d;
  logic [4:0]  code_q;
  logic [4:0]  code_d;
  logic [15:0] opt_q;
  logic [15:0] opt_d;
  oss_src_t    cpu_q;
  oss_src_t    cpu_d;
  logic        per_q;
  logic        per_d;
  logic        ext_q;
  logic        ext_d;
  logic [1:0]  mode_q;
  logic [1:0]  mode_d;
  logic        lsrun_q;
  logic        lsrun_d;
  logic        subrun_q;
  logic        subrun_d;
  logic [3:0]  lsc_q;
  logic [3:0]  lsc_d;
  logic [2:0]  err_q;
  logic [2:0]  err_d;

  // Output state
  logic [6:0]  osc_q;
  logic [6:0]  osc_d;
  logic [5:0]  int_q;
  logic [5:0]  int_d;
  logic        div_q;
  logic        div_d;
  logic        val_q;
  logic        val_d;
  logic        subok_q;
  logic        subok_d;
  logic        osc_en_q;
  logic        osc_en_d;

  // Shared decode
  logic        wr_go;
  logic        sub_lost;
  oss_src_t    cpu_req;

  // True for any mapped register offset
  function automatic logic reg_hit(input logic [11:0] a);
    reg_hit = (a == OFS_CTRL) || (a == OFS_STAT) || (a == OFS_ERR) || (a == OFS_OPT);
  endfunction

  oss_sub_mon #(
    .TIMEOUT (SUB_TIMEOUT)
  ) u_mon (
    .clk      (CLK),
    .rst      (RST),
    .ce       (CE),
    .ext_pin  (SUB_EXT_CLOCK_IN),
    .xtal_pin (SUB_CRYSTAL_IN),
    .lnk      (sub_lnk.mon)
  );

  // Monitor follows the oscillator enable and input choice
  assign sub_lnk.enable  = subrun_q;
  assign sub_lnk.sel_ext = ext_q; // R9

  // Write lands only at the access edge with PREADY high
  assign wr_go   = PSEL && PENABLE && pready_q && PWRITE && reg_hit(PADDR);
  assign cpu_req = oss_src_t'(PWDATA[CTRL_CPU_LSB +: 2]);

  // A selected subsystem clock that stops must be abandoned
  assign sub_lost = !sub_lnk.alive && ((cpu_q == SRC_SUB) || per_q);

  // Bus answer: data latched in setup, one access cycle, no waits
  always_comb
  begin
    pready_d  = PSEL && !PENABLE;
    pslverr_d = PSEL && !PENABLE && !reg_hit(PADDR);
    prdata_d  = prdata_q;
    if (PSEL && !PENABLE)
    begin
      prdata_d = 32'h0;
      unique case (PADDR)
        OFS_CTRL:
        begin
          prdata_d[CTRL_CPU_LSB +: 2]   = cpu_q;
          prdata_d[CTRL_PER_BIT]        = per_q;
          prdata_d[CTRL_EXT_BIT]        = ext_q;
          prdata_d[CTRL_MODE_LSB +: 2]  = mode_q;
          prdata_d[CTRL_LSRUN_BIT]      = lsrun_q;
          prdata_d[CTRL_SUBRUN_BIT]     = subrun_q;
          prdata_d[CTRL_LSC_LSB +: 4]   = lsc_q;
        end
        OFS_STAT:
        begin
          prdata_d[STAT_OSC_LSB +: 7]   = osc_q;
          prdata_d[STAT_INT_LSB +: 6]   = int_q;
          prdata_d[STAT_DIV_BIT]        = div_q;
          prdata_d[STAT_VAL_BIT]        = val_q;
          prdata_d[STAT_LS_BIT]         = lsrun_q;
          prdata_d[STAT_CPU_LSB +: 2]   = cpu_q;
          prdata_d[STAT_PER_BIT]        = per_q;
          prdata_d[STAT_ALIVE_BIT]      = subok_q;
          prdata_d[STAT_CODE_LSB +: 5]  = code_q;
        end
        OFS_ERR:  prdata_d[2:0]  = err_q;
        OFS_OPT:  prdata_d[15:0] = opt_q;
        default:  prdata_d = 32'h0; // Unmapped reads zero with PSLVERR
      endcase
    end
  end

  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      prdata_q  <= 32'h0;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end
    else if (CE)
    begin
      prdata_q  <= prdata_d;
      pready_q  <= pready_d;
      pslverr_q <= pslverr_d;
    end
  end

  // Control: capture options once, then software steers the sources
  always_comb
  begin
    boot_d   = boot_q;
    code_d   = code_q;
    opt_d    = opt_q;
    cpu_d    = cpu_q;
    per_d    = per_q;
    ext_d    = ext_q;
    mode_d   = mode_q;
    lsrun_d  = lsrun_q;
    subrun_d = subrun_q;
    lsc_d    = lsc_q;
    err_d    = err_q;
    unique case (boot_q)
      BOOT_CAPTURE:
      begin
        boot_d  = BOOT_RUN;
        opt_d   = {OPT_HS_BYTE, OPT_LS_BYTE};
        code_d  = OPT_HS_BYTE[HS_SEL_LSB +: HS_SEL_W]; // R11
        lsrun_d = OPT_LS_BYTE[LS_RUN_BIT]; // R7
        cpu_d   = SRC_HS; // R4
      end
      BOOT_RUN:
      begin
        if (wr_go && PADDR == OFS_CTRL)
        begin
          ext_d    = PWDATA[CTRL_EXT_BIT]; // R9
          mode_d   = PWDATA[CTRL_MODE_LSB +: 2]; // R10
          lsrun_d  = PWDATA[CTRL_LSRUN_BIT];
          subrun_d = PWDATA[CTRL_SUBRUN_BIT];
          lsc_d    = PWDATA[CTRL_LSC_LSB +: 4]; // R5
          // Only the on-chip and subsystem clocks may run the CPU
          if (cpu_req == SRC_HS)
            cpu_d = SRC_HS;
          else if (cpu_req == SRC_SUB && sub_lnk.alive)
            cpu_d = SRC_SUB; // R8
          else if (cpu_req == SRC_SUB)
            err_d[ERR_SUB_BIT] = 1'b1;
          else
            err_d[ERR_LSCPU_BIT] = 1'b1; // R6
          // Peripherals switch to the subsystem clock only once it runs
          if (!PWDATA[CTRL_PER_BIT])
            per_d = 1'b0;
          else if (sub_lnk.alive)
            per_d = 1'b1; // R8
          else
            err_d[ERR_SUB_BIT] = 1'b1;
        end
        else if (wr_go && PADDR == OFS_ERR)
          err_d = err_q & ~PWDATA[2:0];
        // Fall back to the on-chip clock when the subsystem clock dies
        if (sub_lost)
        begin
          cpu_d = SRC_HS;
          per_d = 1'b0;
          err_d[ERR_SUB_BIT] = 1'b1;
        end
        // Raised after the clear so a fresh event is never lost
        if (hs_mhz(code_q) == 7'h00)
          err_d[ERR_CODE_BIT] = 1'b1; // R12
      end
    endcase
  end

  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      boot_q   <= BOOT_CAPTURE;
      code_q   <= HS_SAFE_CODE;
      opt_q    <= 16'h0;
      cpu_q    <= SRC_HS; // R4
      per_q    <= 1'b0;
      ext_q    <= 1'b0;
      mode_q   <= RST_MODE;
      lsrun_q  <= 1'b0;
      subrun_q <= 1'b0;
      lsc_q    <= RST_LSC;
      err_q    <= 3'h0;
    end
    else if (CE)
    begin
      boot_q   <= boot_d;
      code_q   <= code_d;
      opt_q    <= opt_d;
      cpu_q    <= cpu_d;
      per_q    <= per_d;
      ext_q    <= ext_d;
      mode_q   <= mode_d;
      lsrun_q  <= lsrun_d;
      subrun_q <= subrun_d;
      lsc_q    <= lsc_d;
      err_q    <= err_d;
    end
  end

  // Frequency outputs; an invalid code runs at the safe 1 MHz setting
  always_comb
  begin
    val_d   = hs_mhz(code_q) != 7'h00; // R12
    osc_d   = val_d ? hs_mhz(code_q) : hs_mhz(HS_SAFE_CODE); // R1
    div_d   = osc_d > HS_UNDIV_MAX_MHZ; // R2
    int_d   = div_d ? osc_d[6:1] : osc_d[5:0]; // R3
    subok_d = sub_lnk.alive;
    // Taken from the next control values so it moves with SUB_EXT_SEL
    osc_en_d = subrun_d && !ext_d; // R9
  end

  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      osc_q   <= 7'h0;
      int_q   <= 6'h0;
      div_q   <= 1'b0;
      val_q   <= 1'b0;
      subok_q <= 1'b0;
      osc_en_q <= 1'b0;
    end
    else if (CE)
    begin
      osc_q   <= osc_d;
      int_q   <= int_d;
      div_q   <= div_d;
      val_q   <= val_d;
      subok_q <= subok_d;
      osc_en_q <= osc_en_d;
    end
  end

  // Every output is a flip-flop; LS_CONSUMER_SEL is not gated by the LS run bit
  assign PRDATA            = prdata_q;
  assign PREADY            = pready_q;
  assign PSLVERR           = pslverr_q;
  assign SUB_OSC_EN        = osc_en_q; // Amplifier off for an external clock
  assign SUB_EXT_SEL       = ext_q;
  assign SUB_OSC_MODE      = mode_q; // R10
  assign HS_OSC_FREQ       = osc_q;
  assign HS_INTERNAL_CLOCK = int_q;
  assign HS_DIV2           = div_q;
  assign HS_FREQ_VALID     = val_q;
  assign CPU_CLK_SRC       = cpu_q;
  assign PERIPH_CLK_SRC    = per_q;
  assign LS_OSC_RUN        = lsrun_q;
  assign LS_CONSUMER_SEL   = lsc_q;
  assign SUB_CLK_OK        = subok_q;

endmodule // oss_select_top

// ==== core/oss_sub_if.sv ====
/*
  Link between the select logic and the subsystem clock monitor.
  Assumes both ends run on the same system clock.
*/
`timescale 1ns/1ps
interface oss_sub_if;
  logic enable;
  logic sel_ext;
  logic alive;

  // Select logic drives the mode, monitor reports activity
  modport ctl (output enable, output sel_ext, input alive);
  modport mon (input enable, input sel_ext, output alive);
endinterface

// ==== core/oss_sub_mon.sv ====
/*
  Subsystem clock activity monitor. Samples either the crystal input or
  the external clock input, both asynchronous pins, with a three stage
  synchroniser and flags the clock alive while edges keep coming.
*/
`timescale 1ns/1ps
module oss_sub_mon
  import oss_pkg::*;
#(
  parameter int TIMEOUT = SUB_TIMEOUT_CYC
)
(
  // Clock, reset, enable
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic ce,
  // Pins
  input  wire logic ext_pin,
  input  wire logic xtal_pin,
  // Control link
  oss_sub_if.mon    lnk
);

  logic [2:0]  sync_q;
  logic [2:0]  sync_d;
  logic        level_q;
  logic        level_d;
  logic [16:0] cnt_q;
  logic [16:0] cnt_d;
  logic        alive_q;
  logic        alive_d;

  // Pick the pin, then let it settle before counting edges
  always_comb
  begin
    sync_d  = {sync_q[1:0], lnk.sel_ext ? ext_pin : xtal_pin};
    level_d = level_q;
    cnt_d   = cnt_q;
    alive_d = alive_q;
    if (!lnk.enable)
    begin
      cnt_d   = 17'h0;
      alive_d = 1'b0;
    end
    else if (sync_q[2] == sync_q[1] && sync_q[2] != level_q)
    begin
      level_d = sync_q[2];
      cnt_d   = 17'h0;
      alive_d = 1'b1;
    end
    else if (cnt_q >= 17'(TIMEOUT - 1))
      alive_d = 1'b0; // Silent too long: alive drops until the next settled edge raises it again
    else
      cnt_d = cnt_q + 17'h1;
  end

  // Registers
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      sync_q  <= 3'h0;
      level_q <= 1'b0;
      cnt_q   <= 17'h0;
      alive_q <= 1'b0;
    end
    else if (ce)
    begin
      sync_q  <= sync_d;
      level_q <= level_d;
      cnt_q   <= cnt_d;
      alive_q <= alive_d;
    end
  end

  assign lnk.alive = alive_q;

endmodule // oss_sub_mon

// ==== verification/oss_select_properties.sv ====
/*
  Timing checks on the oscillator source select outputs.
  Assumes the option bytes are steady across reset release.
*/
`timescale 1ns/1ps
module oss_select_properties
  import oss_pkg::*;
(
  // Clock and reset
  input wire logic       CLK,
  input wire logic       RST,
  // Watched ports
  input wire logic [7:0] OPT_LS_BYTE,
  input wire logic       SUB_OSC_EN,
  input wire logic       SUB_EXT_SEL,
  input wire logic [1:0] SUB_OSC_MODE,
  input wire logic [6:0] HS_OSC_FREQ,
  input wire logic [5:0] HS_INTERNAL_CLOCK,
  input wire logic       HS_DIV2,
  input wire logic       HS_FREQ_VALID,
  input wire logic [1:0] CPU_CLK_SRC,
  input wire logic       PERIPH_CLK_SRC,
  input wire logic       LS_OSC_RUN,
  input wire logic       SUB_CLK_OK
);
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RST);
  // Source selection
  cpu_not_ls_a: assert property (CPU_CLK_SRC != SRC_LS)
    else $error("CPU source is the low-speed clock");
  reset_cpu_hs_a: assert property ($past(RST) |-> (CPU_CLK_SRC == SRC_HS) [*2])
    else $error("CPU source not on-chip clock after reset");
  sub_use_ok_a: assert property (CPU_CLK_SRC == SRC_SUB || PERIPH_CLK_SRC |-> SUB_CLK_OK)
    else $error("Subsystem clock used while not alive");
  sub_pin_one_a: assert property (SUB_OSC_EN |-> !SUB_EXT_SEL)
    else $error("Crystal amplifier on with external input");
  mode_reset_a: assert property ($past(RST) |-> SUB_OSC_MODE == RST_MODE)
    else $error("Oscillation mode wrong after reset");
  // Frequency decode
  hs_halved_a: assert property (HS_OSC_FREQ > HS_UNDIV_MAX_MHZ |->
    HS_DIV2 && HS_INTERNAL_CLOCK == HS_OSC_FREQ[6:1])
    else $error("Internal clock not halved");
  hs_undivided_a: assert property (HS_OSC_FREQ <= HS_UNDIV_MAX_MHZ |->
    !HS_DIV2 && HS_INTERNAL_CLOCK == HS_OSC_FREQ[5:0])
    else $error("Internal clock divided below limit");
  freq_legal_a: assert property (HS_FREQ_VALID |->
    HS_OSC_FREQ inside {7'h40, 7'h30, 7'h20, 7'h18, 7'h10, 7'h0c, 7'h08, 7'h04, 7'h01})
    else $error("Valid code gives unlisted frequency");
  invalid_one_a: assert property (!HS_FREQ_VALID && !$past(RST) && !$past(RST, 2) |->
    HS_OSC_FREQ == 7'h01)
    else $error("Invalid code does not show 1 MHz");
  // Low-speed start from option bit, checked once capture has landed
  ls_run_init_a: assert property ($past(RST, 2) && !$past(RST) |->
    LS_OSC_RUN == OPT_LS_BYTE[LS_RUN_BIT])
    else $error("Low-speed run differs from option bit");
endmodule // oss_select_properties

bind oss_select_top oss_select_properties oss_select_properties_inst (.CLK(CLK), .RST(RST),
  .OPT_LS_BYTE(OPT_LS_BYTE), .SUB_OSC_EN(SUB_OSC_EN), .SUB_EXT_SEL(SUB_EXT_SEL),
  .SUB_OSC_MODE(SUB_OSC_MODE), .HS_OSC_FREQ(HS_OSC_FREQ), .HS_INTERNAL_CLOCK(HS_INTERNAL_CLOCK),
  .HS_DIV2(HS_DIV2), .HS_FREQ_VALID(HS_FREQ_VALID), .CPU_CLK_SRC(CPU_CLK_SRC),
  .PERIPH_CLK_SRC(PERIPH_CLK_SRC), .LS_OSC_RUN(LS_OSC_RUN), .SUB_CLK_OK(SUB_CLK_OK));

// ==== verification/oss_select_top_tb.sv ====
/*
  Self-checking bench for the oscillator source select block over APB.
  Assumes a 100 MHz clock and a short subsystem timeout of 20 cycles.
*/
`timescale 1ns/1ps
module oss_select_top_tb
  import oss_pkg::*;
;
  localparam int TMO = 20;
  localparam logic [6:0] MHZ [9] = '{7'h40, 7'h30, 7'h20, 7'h18, 7'h10, 7'h0c, 7'h08, 7'h04, 7'h01};
  logic clk = 1'b0, rst = 1'b1, ce = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0, ext_run = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata;
  logic [7:0] opt_ls = 8'h00, opt_hs = 8'h00;
  logic pready, pslverr, ex_in, xt_in, osc_en, ext_sel, hdiv, hval, per, lsrun, subok;
  logic [1:0] mode, cpu;
  logic [6:0] hfreq;
  logic [5:0] hint;
  logic [3:0] lsc, lsc_w;
  logic [32:0] exp_q [$];
  int n_errors = 0, n_checks = 0;

  // Free-running clock
  always #5 clk = ~clk;

  oss_select_top #(.SUB_TIMEOUT(20)) oss_select_top_inst (.CLK(clk), .RST(rst), .CE(ce),
    .PSEL(psel), .PENABLE(pen), .PWRITE(pwr), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .OPT_LS_BYTE(opt_ls), .OPT_HS_BYTE(opt_hs),
    .SUB_EXT_CLOCK_IN(ex_in), .SUB_CRYSTAL_IN(xt_in), .SUB_OSC_EN(osc_en), .SUB_EXT_SEL(ext_sel),
    .SUB_OSC_MODE(mode), .HS_OSC_FREQ(hfreq), .HS_INTERNAL_CLOCK(hint), .HS_DIV2(hdiv),
    .HS_FREQ_VALID(hval), .CPU_CLK_SRC(cpu), .PERIPH_CLK_SRC(per), .LS_OSC_RUN(lsrun),
    .LS_CONSUMER_SEL(lsc), .SUB_CLK_OK(subok));

  oss_sub_clk_model oss_sub_clk_model_inst (.clk(clk), .amp_en(osc_en), .ext_run(ext_run),
    .ext_pin(ex_in), .xtal_pin(xt_in));

  task automatic conclude;
    $display("Errors %0d, checks %0d", n_errors, n_checks);
    if (n_errors == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic check(input logic [32:0] seen, input logic [32:0] want);
    n_checks++;
    if (seen !== want)
    begin
      n_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask

  // One APB transfer; psel stays up so a following setup can come at once
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwr <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < TMO);
    if (pready !== 1'b1)
    begin
      n_errors++;
      conclude();
    end
    pen <= 1'b0;
  endtask

  task automatic idle(input int n);
    psel <= 1'b0;
    repeat (n) @(posedge clk);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic err = 1'b0);
    exp_q.push_back({err, e});
    apb(1'b0, a, 32'h0);
  endtask

  task automatic boot(input logic [4:0] c, input logic ls);
    opt_hs <= {3'h0, c};
    opt_ls <= {3'h0, ls, 4'h0};
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
  endtask

  // Status word as the decode must show it
  function automatic logic [31:0] stat(input logic [4:0] c, input logic ls, input logic [1:0] cp,
                                       input logic pr, input logic ok);
    logic [6:0] f;
    f = (c < 5'h09) ? MHZ[c] : 7'h01;
    stat = {3'h0, c, 3'h0, ok, pr, cp, ls, c < 5'h09, f > 7'h20, (f > 7'h20) ? f[6:1] : f[5:0], 1'b0, f};
  endfunction

  // Read results are matched in order against the driver's notes
  always @(posedge clk)
    if (psel && pen && pready === 1'b1 && !pwr)
      check({pslverr, prdata}, exp_q.pop_front());

  initial
  begin
    logic [4:0] c;
    logic ls;
    logic [31:0] s;
    void'($urandom(46987));
    @(posedge clk);
    // Every frequency code, then code 9 and a random unassigned one
    for (int i = 0; i < 11; i++)
    begin
      c = (i < 10) ? 5'(i) : 5'(10 + $urandom % 22);
      ls = 1'($urandom % 2);
      boot(c, ls);
      s = stat(c, ls, 2'h0, 1'b0, 1'b0);
      // The output pins must show the same decode as the status word
      check(33'({subok, per, cpu, lsrun, hval, hdiv, hint, 1'b0, hfreq}), 33'(s[20:0]));
      rd(OFS_STAT, s);
      rd(OFS_OPT, {16'h0, opt_hs, opt_ls});
      rd(OFS_ERR, {31'h0, c > 5'h08});
      idle(1);
    end
    boot(5'h00, 1'b1);
    lsc_w = 4'($urandom);
    // Low-speed clock asked for the CPU is refused, consumers still land
    apb(1'b1, OFS_CTRL, {20'h0, lsc_w, 8'h42});
    apb(1'b1, OFS_STAT, 32'hffffffff);
    rd(OFS_CTRL, {20'h0, lsc_w, 8'h40});
    rd(OFS_ERR, 32'h2);
    rd(12'h010, 32'h0, 1'b1);
    apb(1'b1, OFS_ERR, 32'h7);
    idle(2);
    check(33'(lsc), 33'(lsc_w));
    // Subsystem asked while dead
    apb(1'b1, OFS_CTRL, 32'h45);
    rd(OFS_STAT, stat(5'h00, 1'b1, 2'h0, 1'b0, 1'b0));
    rd(OFS_ERR, 32'h4);
    apb(1'b1, OFS_ERR, 32'h7);
    apb(1'b1, OFS_CTRL, 32'hc0);
    idle(60);
    check(33'({osc_en, ext_sel}), 33'h2);
    apb(1'b1, OFS_CTRL, 32'hc5);
    rd(OFS_STAT, stat(5'h00, 1'b1, 2'h1, 1'b1, 1'b1));
    // External input with every oscillation mode
    ext_run <= 1'b1;
    for (int m = 0; m < 4; m++)
    begin
      apb(1'b1, OFS_CTRL, 32'hcd | (m << CTRL_MODE_LSB));
      idle(30);
      check(33'({osc_en, ext_sel, mode}), 33'({2'h1, 2'(m)}));
    end
    rd(OFS_STAT, stat(5'h00, 1'b1, 2'h1, 1'b1, 1'b1));
    // Source stops while CE is low: nothing may move until CE returns
    ext_run <= 1'b0;
    ce <= 1'b0;
    idle(60);
    check(33'({cpu, per, subok}), 33'h7);
    // Then the selection falls back and the loss is flagged
    ce <= 1'b1;
    idle(60);
    rd(OFS_STAT, stat(5'h00, 1'b1, 2'h0, 1'b0, 1'b0));
    rd(OFS_ERR, 32'h4);
    idle(3);
    conclude();
  end
endmodule // oss_select_top_tb

// ==== verification/oss_sub_clk_model.sv ====
/*
  Far-side model of the subsystem clock sources: crystal and external clock.
  Assumes the bench clock as its time base; each source toggles every 4 cycles.
*/
`timescale 1ns/1ps
module oss_sub_clk_model
(
  // Time base and controls
  input  wire logic clk,
  input  wire logic amp_en,
  input  wire logic ext_run,
  // Pins
  output logic      ext_pin,
  output logic      xtal_pin
);
  logic [1:0] div_q = 2'h0;
  initial xtal_pin = 1'b0;
  initial ext_pin = 1'b0;
  // A stopped source stands still, so the monitor must see it die
  always @(posedge clk)
  begin
    div_q <= div_q + 2'h1;
    if (div_q == 2'h3 && amp_en) xtal_pin <= ~xtal_pin;
    if (div_q == 2'h3 && ext_run) ext_pin <= ~ext_pin;
  end
endmodule // oss_sub_clk_model
